// File: dv/ptmr_monitor.sv
// port checker for one timer pair, bound to the pair's top module
`timescale 1ns/100ps
`default_nettype none
module ptmr_monitor
    import ptmr_pkg::*;
#(
    parameter bit ADC_TRIG_EN = 1'b0  // same figure as the watched pair
)(
    input wire logic              ref_clk,
    input wire logic              resetn,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wrData,
    input wire logic              wrStb,
    input wire logic              rdStb,
    input wire logic [DATA_W-1:0] rdData,
    input wire logic              cpuIdle,
    input wire logic              lowTimerClkPin,
    input wire logic              highTimerClkPin,
    input wire logic              irq,
    input wire logic              lowMatch,
    input wire logic              pairInterruptFlag,
    input wire logic              adcTrigger
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // read data only in the answer cycle, else zero
    a_read_idle_zero: assert property (!rdStb |=> rdData == ZERO_WORD)
        else $error("read data seen outside answer cycle");
    a_unmapped_read: assert property (rdStb && addr > REG_IRQ_MASK |=> rdData == ZERO_WORD)
        else $error("unmapped read not zero");
    // flag is sticky until software clears it
    a_flag_sticky: assert property (pairInterruptFlag &&
        !(wrStb && addr == REG_IRQ_STAT && wrData[1]) |=> pairInterruptFlag)
        else $error("pair flag dropped without clear");
    // a clear loses only against a same-cycle match
    a_flag_clear: assert property (pairInterruptFlag && wrStb &&
        addr == REG_IRQ_STAT && wrData[1] |=> !pairInterruptFlag || adcTrigger || !ADC_TRIG_EN)
        else $error("pair flag not cleared");
    a_trig_with_flag: assert property (adcTrigger |-> pairInterruptFlag)
        else $error("trigger without pair flag");
    // irq rises on a match or a mask write only
    a_irq_rise_cause: assert property ($rose(irq) |-> lowMatch ||
        $rose(pairInterruptFlag) || ($past(wrStb) && $past(addr) == REG_IRQ_MASK))
        else $error("irq rose without cause");
    a_irq_fall_cause: assert property ($fell(irq) |-> $past(wrStb) &&
        ($past(addr) == REG_IRQ_STAT || $past(addr) == REG_IRQ_MASK))
        else $error("irq fell without write");
    a_mask_zero_quiet: assert property (wrStb && addr == REG_IRQ_MASK &&
        wrData == ZERO_WORD |=> !irq)
        else $error("irq high with mask zero");
    c_low_match: cover property (lowMatch);
    c_adc_trig: cover property (adcTrigger);
    c_irq_clear: cover property ($fell(irq));
endmodule
`default_nettype wire

// File: dv/ptmr_pin_model.sv
// far side: drives both external timer pins, idle low between uses
`timescale 1ns/100ps
`default_nettype none
module ptmr_pin_model (
    input  wire logic ref_clk,
    output logic      lowPin,
    output logic      highPin
);
    initial begin
        lowPin = 1'b0;
        highPin = 1'b0;
    end
    // n rising edges on both pins, slow enough for the synchroniser
    task automatic burst(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            lowPin <= 1'b1;
            highPin <= 1'b1;
            repeat (3) @(posedge ref_clk);
            lowPin <= 1'b0;
            highPin <= 1'b0;
            repeat (3) @(posedge ref_clk);
        end
    endtask
    // steady gate level on the low pin
    task automatic level(input logic v);
        @(posedge ref_clk);
        lowPin <= v;
    endtask
endmodule
`default_nettype wire

// File: dv/tb_ptmr_top.sv
// self-checking bench for one timer pair
`timescale 1ns/100ps
`default_nettype none
module tb_ptmr_top;
    import ptmr_pkg::*;
    logic ref_clk, resetn, wrStb, rdStb, cpuIdle;
    logic [3:0] addr;
    logic [15:0] wrData, rv, rdData;
    logic irq, lowMatch, pairInterruptFlag, adcTrigger;
    wire logic lowPin, highPin;
    int fail_count = 0;
    int samples_checked = 0;
    int lowSeen = 0;  // low match pulses seen
    int lowBase;      // lowSeen at the start of the pair match test
    int n;            // cycles counted by the last wait
    logic [15:0] rstTab [10] = '{CTRL_RESET, CTRL_RESET, PERIOD_RESET, PERIOD_RESET,
        COUNT_RESET, COUNT_RESET, ZERO_WORD, ZERO_WORD, ZERO_WORD, ZERO_WORD};
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (lowMatch === 1'b1) lowSeen++;
    ptmr_top #(.ADC_TRIG_EN(1'b1)) uut (.ref_clk(ref_clk), .resetn(resetn), .addr(addr),
        .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .cpuIdle(cpuIdle),
        .lowTimerClkPin(lowPin), .highTimerClkPin(highPin), .irq(irq), .lowMatch(lowMatch),
        .pairInterruptFlag(pairInterruptFlag), .adcTrigger(adcTrigger));
    ptmr_pin_model pins (.ref_clk(ref_clk), .lowPin(lowPin), .highPin(highPin));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one-cycle write, master never waits
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        wrData <= d;
        wrStb <= 1'b1;
        @(posedge ref_clk);
        wrStb <= 1'b0;
    endtask
    // read answer stands only in the next cycle
    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge ref_clk);
        rdStb <= 1'b0;
        #1 rv = rdData;
    endtask
    // bounded wait for a match pulse, n counts the cycles
    task automatic wait_pulse(input bit sel, input int lim);
        n = 0;
        do begin
            @(posedge ref_clk);
            #1 n++;
        end while ((sel ? adcTrigger : lowMatch) !== 1'b1 && n < lim);
        if ((sel ? adcTrigger : lowMatch) !== 1'b1) begin
            fail_count++;
            $display("Error at %0t: match pulse missing", $time);
            give_verdict();
        end
    endtask
    initial begin
        ref_clk = 1'b0;
        resetn = 1'b0;
        {wrStb, rdStb, cpuIdle, addr, wrData} = '0;
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        foreach (rstTab[i]) begin
            rd(4'(i));
            chk(rv, rstTab[i]);
        end
        // unimplemented control bits read zero
        wr(REG_LO_CTRL, 16'h7FFF);
        rd(REG_LO_CTRL);
        chk(rv, 16'h207A);
        wr(REG_HI_CTRL, 16'h7FFF);
        rd(REG_HI_CTRL);
        chk(rv, 16'h2072);
        wr(REG_HI_CTRL, 16'h0000);
        // match interval is (period+1) times the divide ratio
        wr(REG_LO_PERIOD, 16'h0003);
        wr(REG_IRQ_MASK, 16'h0003);
        for (int p = 0; p < 4; p++) begin
            wr(REG_LO_CTRL, {1'b1, 9'h0, 2'(p), 4'h0});
            wait_pulse(1'b0, 2000);
            wait_pulse(1'b0, 2000);
            chk(n, 4 << ((p == 3) ? 8 : 3 * p));
        end
        wr(REG_LO_CTRL, 16'h0000);
        chk(irq, 1'b1);
        wr(REG_IRQ_MASK, 16'h0000);
        #1 chk(irq, 1'b0);
        wr(REG_IRQ_MASK, 16'h0003);
        wr(REG_IRQ_STAT, 16'h0001);
        rd(REG_IRQ_STAT);
        chk(rv, 16'h0000);
        // idle halts only with idle stop set
        wr(REG_LO_COUNT, 16'h0000);
        @(posedge ref_clk) cpuIdle <= 1'b1;
        wr(REG_LO_CTRL, 16'hA000);
        repeat (20) @(posedge ref_clk);
        rd(REG_LO_COUNT);
        chk(rv, 16'h0000);
        wr(REG_LO_CTRL, 16'h8000);
        repeat (20) @(posedge ref_clk);
        wr(REG_LO_CTRL, 16'h0000);
        rd(REG_LO_COUNT);
        chk(rv != 16'h0000, 1'b1);
        n = rv;
        repeat (10) @(posedge ref_clk);
        rd(REG_LO_COUNT);
        chk(rv, n);
        @(posedge ref_clk) cpuIdle <= 1'b0;
        // pair mode: carry into high word, hold latched on low read
        wr(REG_LO_COUNT, 16'hFFFF);
        wr(REG_HI_COUNT, 16'h0002);
        wr(REG_HI_CTRL, 16'h8032);
        wr(REG_LO_CTRL, 16'h8008);
        repeat (5) @(posedge ref_clk);
        wr(REG_LO_CTRL, 16'h0008);
        rd(REG_LO_COUNT);
        rd(REG_HOLD);
        chk(rv, 16'h0003);
        rd(REG_HI_COUNT);
        chk(rv, 16'h0003);
        // 32-bit period match, flag on the high side only
        wr(REG_HI_CTRL, 16'h0000);
        wr(REG_LO_PERIOD, 16'h0000);
        wr(REG_HI_PERIOD, 16'h0001);
        wr(REG_HI_COUNT, 16'h0000);
        wr(REG_LO_COUNT, 16'hFFF0);
        wr(REG_IRQ_STAT, 16'h0003);
        lowBase = lowSeen;
        wr(REG_LO_CTRL, 16'h8008);
        wait_pulse(1'b1, 100);
        wait_pulse(1'b1, 70000);
        chk(n, 32'h0001_0001);
        chk(pairInterruptFlag, 1'b1);
        chk(lowSeen - lowBase, 0);
        wr(REG_IRQ_STAT, 16'h0002);
        rd(REG_IRQ_STAT);
        chk(rv, 16'h0000);
        // separate mode, pin clocks; gate ignored on the pin source
        wr(REG_LO_CTRL, 16'h0000);
        wr(REG_LO_PERIOD, 16'hFFFF);
        wr(REG_HI_PERIOD, 16'hFFFF);
        wr(REG_LO_COUNT, 16'h0000);
        wr(REG_HI_COUNT, 16'h0000);
        wr(REG_LO_CTRL, 16'h8042);
        wr(REG_HI_CTRL, 16'h8002);
        pins.burst(5);
        repeat (6) @(posedge ref_clk);
        rd(REG_LO_COUNT);
        chk(rv, 16'h0005);
        rd(REG_HI_COUNT);
        chk(rv, 16'h0005);
        // gated internal clock counts only while the pin is high
        wr(REG_LO_CTRL, 16'h0000);
        wr(REG_LO_COUNT, 16'h0000);
        wr(REG_LO_CTRL, 16'h8040);
        repeat (20) @(posedge ref_clk);
        rd(REG_LO_COUNT);
        chk(rv, 16'h0000);
        pins.level(1'b1);
        repeat (20) @(posedge ref_clk);
        pins.level(1'b0);
        repeat (5) @(posedge ref_clk);
        rd(REG_LO_COUNT);
        chk(rv != 16'h0000, 1'b1);
        give_verdict();
    end
endmodule
bind ptmr_top ptmr_monitor #(.ADC_TRIG_EN(ADC_TRIG_EN)) mon (.ref_clk(ref_clk),
    .resetn(resetn), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
    .rdData(rdData), .cpuIdle(cpuIdle), .lowTimerClkPin(lowTimerClkPin),
    .highTimerClkPin(highTimerClkPin), .irq(irq), .lowMatch(lowMatch),
    .pairInterruptFlag(pairInterruptFlag), .adcTrigger(adcTrigger));
`default_nettype wire

// File: pkg/ptmr_pkg.sv
// paired 16/32-bit timer: register map, field layouts, reset values
// Functional notes
// - pair-mode bit joins both timers to 32
// - pair mode ignores high control register
// - pair uses low clock/gate, high flag
// - 32-bit period is high:low period words
// - 32-bit count is high:low count words
// - run bit starts, stops the timer
// - idle-stop bit halts timer in idle
// - gate counts internal clock while pin high
// - prescale 1, 8, 64 or 256
// - clock source selects pin edges or internal
// - period match raises the timer flag
// - adc trigger only on second pair's high
// - every timer is a synchronous timer/counter
// - high control bits 3-2 unimplemented, read zero
// - count clears to zero on period match
package ptmr_pkg;
    localparam int          ADDR_W        = 4;
    localparam int          DATA_W        = 16;
    // register word offsets
    localparam logic [3:0]  REG_LO_CTRL   = 4'h0;
    localparam logic [3:0]  REG_HI_CTRL   = 4'h1;
    localparam logic [3:0]  REG_LO_PERIOD = 4'h2;
    localparam logic [3:0]  REG_HI_PERIOD = 4'h3;
    localparam logic [3:0]  REG_LO_COUNT  = 4'h4;
    localparam logic [3:0]  REG_HI_COUNT  = 4'h5;
    localparam logic [3:0]  REG_HOLD      = 4'h6;
    localparam logic [3:0]  REG_IRQ_STAT  = 4'h7;
    localparam logic [3:0]  REG_IRQ_MASK  = 4'h8;
    // writable bits of each control register
    localparam logic [15:0] LO_CTRL_WMASK = 16'hA07A;
    localparam logic [15:0] HI_CTRL_WMASK = 16'hA072;
    // reset values
    localparam logic [15:0] CTRL_RESET    = 16'h0000;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;
    localparam logic [15:0] PERIOD_RESET  = 16'hFFFF;
    localparam logic [15:0] ZERO_WORD     = 16'h0000;
    localparam logic [15:0] ONE_WORD      = 16'h0001;
    localparam logic [31:0] ONE_DWORD     = 32'h0000_0001;
    // prescale encodings and divider terminal counts
    localparam logic [1:0]  PS_DIV1       = 2'h0;
    localparam logic [1:0]  PS_DIV8       = 2'h1;
    localparam logic [1:0]  PS_DIV64      = 2'h2;
    localparam logic [1:0]  PS_DIV256     = 2'h3;
    localparam logic [7:0]  PS_TERM1      = 8'h00;
    localparam logic [7:0]  PS_TERM8      = 8'h07;
    localparam logic [7:0]  PS_TERM64     = 8'h3F;
    localparam logic [7:0]  PS_TERM256    = 8'hFF;
    localparam logic [7:0]  PS_ZERO       = 8'h00;
    localparam logic [7:0]  PS_ONE        = 8'h01;
    // interrupt status / mask layout
    localparam int          IRQ_W         = 2;
    localparam int          IRQ_LO        = 0;
    localparam int          IRQ_HI        = 1;
    localparam logic [1:0]  IRQ_RESET     = 2'h0;

    // control register layout, bit 15 down to bit 0
    typedef struct packed {
        logic       timerRun;            // bit 15
        logic       rsv14;               // bit 14
        logic       idleStop;            // bit 13
        logic [5:0] rsv12to7;            // bits 12..7
        logic       gateAccumulateEnable; // bit 6
        logic [1:0] prescaleSelect;      // bits 5..4
        logic       pairModeSelect;      // bit 3, low timer only
        logic       rsv2;                // bit 2
        logic       clockSourceSelect;   // bit 1
        logic       rsv0;                // bit 0
    } ptmr_ctrl_t;

    // register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
        logic              wrStb;
        logic              rdStb;
    } ptmr_bus_t;
endpackage

// File: verilog/ptmr_pin_sync.sv
// two-flop synchroniser with rising edge detect for one timer pin
`timescale 1ns/100ps
`default_nettype none
module ptmr_pin_sync
    import ptmr_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic pinIn,
    output logic      level,
    output logic      rise
);
    // meta stage, sync stage, previous sync value
    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } ptmr_sync_t;

    ptmr_sync_t state_ff;   // registered state
    ptmr_sync_t nxt_state;  // next state

    // meta is read only by sync
    always_comb begin
        nxt_state      = state_ff;
        nxt_state.meta = pinIn;
        nxt_state.sync = state_ff.meta;
        nxt_state.last = state_ff.sync;
    end

    // state register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign level = state_ff.sync;
    assign rise  = state_ff.sync & ~state_ff.last;
endmodule
`default_nettype wire

// File: verilog/ptmr_prescale.sv
// input clock prescaler: passes one tick in 1, 8, 64 or 256
`timescale 1ns/100ps
`default_nettype none
module ptmr_prescale
    import ptmr_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic       tickIn,
    input  wire logic       clear,
    input  wire logic [1:0] prescaleSel,
    output logic            tickOut
);
    typedef struct packed {
        logic [7:0] cnt;    // ticks seen since last output
    } ptmr_ps_t;

    ptmr_ps_t   state_ff;   // registered state
    ptmr_ps_t   nxt_state;  // next state
    logic [7:0] term;       // terminal count for ratio

    // ratio decode
    always_comb begin
        unique case (prescaleSel)
            PS_DIV1:   term = PS_TERM1;
            PS_DIV8:   term = PS_TERM8;
            PS_DIV64:  term = PS_TERM64;
            PS_DIV256: term = PS_TERM256;
        endcase
    end

    // counter; clear keeps a stopped timer from carrying a partial count
    always_comb begin
        nxt_state = state_ff;
        if (clear) begin
            nxt_state.cnt = PS_ZERO;
        end else if (tickIn) begin
            nxt_state.cnt = (state_ff.cnt >= term) ? PS_ZERO : state_ff.cnt + PS_ONE;
        end
    end

    // state register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign tickOut = tickIn & ~clear & (state_ff.cnt >= term);
endmodule
`default_nettype wire

// File: verilog/ptmr_top.sv
// one timer pair: two 16-bit timers or one joined 32-bit timer
`timescale 1ns/100ps
`default_nettype none
module ptmr_top
    import ptmr_pkg::*;
#(
    parameter bit ADC_TRIG_EN = 1'b0  // set only on the second pair
)(
    input  wire logic              ref_clk,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wrData,
    input  wire logic              wrStb,
    input  wire logic              rdStb,
    output logic      [DATA_W-1:0] rdData,
    input  wire logic              cpuIdle,
    input  wire logic              lowTimerClkPin,
    input  wire logic              highTimerClkPin,
    output logic                   irq,
    output logic                   lowMatch,
    output logic                   pairInterruptFlag,
    output logic                   adcTrigger
);
    // all block state
    typedef struct packed {
        ptmr_ctrl_t        loCtrl;      // low timer control
        ptmr_ctrl_t        hiCtrl;      // high timer control
        logic [15:0]       loPeriod;    // low period word
        logic [15:0]       hiPeriod;    // high period word
        logic [15:0]       loCount;     // low count word
        logic [15:0]       hiCount;     // high count word
        logic [15:0]       hold;        // upper count hold
        logic [IRQ_W-1:0]  status;      // sticky match flags
        logic [IRQ_W-1:0]  mask;        // interrupt mask
        logic [DATA_W-1:0] rdData;      // read answer
        logic              loMatch;     // low match pulse
        logic              hiMatch;     // high/pair match pulse
        logic              adcTrig;     // adc trigger pulse
    } ptmr_state_t;

    ptmr_state_t state_ff;   // registered state
    ptmr_state_t nxt_state;  // next state
    ptmr_bus_t   bus;        // bundled request

    logic loPinLevel;        // synchronised low pin
    logic loPinRise;         // low pin rising edge
    logic hiPinLevel;        // synchronised high pin
    logic hiPinRise;         // high pin rising edge
    logic pairMode;          // timers joined
    logic loActive;          // low timer may count
    logic hiActive;          // high timer may count
    logic loRaw;             // low timer input clock
    logic hiRaw;             // high timer input clock
    logic loTick;            // prescaled low tick
    logic hiTick;            // prescaled high tick
    logic [31:0] count32;    // joined count
    logic [31:0] period32;   // joined period
    logic [IRQ_W-1:0] setFlags; // events this cycle
    logic [IRQ_W-1:0] clrFlags; // software clears

    assign bus.addr   = addr;
    assign bus.wrData = wrData;
    assign bus.wrStb  = wrStb;
    assign bus.rdStb  = rdStb;

    // pins cross into ref_clk before use
    ptmr_pin_sync u_lo_sync (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .pinIn   (lowTimerClkPin),
        .level   (loPinLevel),
        .rise    (loPinRise)
    );

    ptmr_pin_sync u_hi_sync (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .pinIn   (highTimerClkPin),
        .level   (hiPinLevel),
        .rise    (hiPinRise)
    );

    // mode decode
    assign pairMode = state_ff.loCtrl.pairModeSelect;

    // run gating: run bit, and idle halts only with idle-stop set
    always_comb begin
        loActive = state_ff.loCtrl.timerRun
                 & ~(cpuIdle & state_ff.loCtrl.idleStop);
        // the high control register has no say once joined
        hiActive = ~pairMode & state_ff.hiCtrl.timerRun
                 & ~(cpuIdle & state_ff.hiCtrl.idleStop);
    end

    // input clock select; gate only meaningful on the internal clock
    always_comb begin
        if (state_ff.loCtrl.clockSourceSelect) begin
            loRaw = loPinRise;
        end else if (state_ff.loCtrl.gateAccumulateEnable) begin
            loRaw = loPinLevel;
        end else begin
            loRaw = 1'b1;
        end
        if (state_ff.hiCtrl.clockSourceSelect) begin
            hiRaw = hiPinRise;
        end else if (state_ff.hiCtrl.gateAccumulateEnable) begin
            hiRaw = hiPinLevel;
        end else begin
            hiRaw = 1'b1;
        end
    end

    // low prescaler also drives the joined timer
    ptmr_prescale u_lo_ps (
        .ref_clk     (ref_clk),
        .resetn      (resetn),
        .tickIn      (loRaw & loActive),
        .clear       (~loActive),
        .prescaleSel (state_ff.loCtrl.prescaleSelect),
        .tickOut     (loTick)
    );

    ptmr_prescale u_hi_ps (
        .ref_clk     (ref_clk),
        .resetn      (resetn),
        .tickIn      (hiRaw & hiActive),
        .clear       (~hiActive),
        .prescaleSel (state_ff.hiCtrl.prescaleSelect),
        .tickOut     (hiTick)
    );

    // joined views of count and period
    assign count32  = {state_ff.hiCount, state_ff.loCount};
    assign period32 = {state_ff.hiPeriod, state_ff.loPeriod};

    // software clear of sticky flags, write-one-to-clear
    always_comb begin
        clrFlags = '0;
        if (bus.wrStb && bus.addr == REG_IRQ_STAT) begin
            clrFlags = bus.wrData[IRQ_W-1:0];
        end
    end

    // next-state logic: counting, matches, register bus
    always_comb begin
        nxt_state         = state_ff;
        setFlags          = '0;
        nxt_state.loMatch = 1'b0;
        nxt_state.hiMatch = 1'b0;
        nxt_state.adcTrig = 1'b0;
        nxt_state.rdData  = ZERO_WORD;

        // counting, only on prescaled ticks
        if (pairMode) begin
            if (loTick) begin
                if (count32 == period32) begin
                    // wrap to zero and keep going
                    nxt_state.loCount = COUNT_RESET;
                    nxt_state.hiCount = COUNT_RESET;
                    setFlags[IRQ_HI]  = 1'b1;
                    nxt_state.hiMatch = 1'b1;
                    nxt_state.adcTrig = ADC_TRIG_EN;
                end else begin
                    // carry ripples from low word into high word
                    {nxt_state.hiCount, nxt_state.loCount} = count32 + ONE_DWORD;
                end
            end
        end else begin
            // independent low timer
            if (loTick) begin
                if (state_ff.loCount == state_ff.loPeriod) begin
                    nxt_state.loCount = COUNT_RESET;
                    setFlags[IRQ_LO]  = 1'b1;
                    nxt_state.loMatch = 1'b1;
                end else begin
                    nxt_state.loCount = state_ff.loCount + ONE_WORD;
                end
            end
            // independent high timer
            if (hiTick) begin
                if (state_ff.hiCount == state_ff.hiPeriod) begin
                    nxt_state.hiCount = COUNT_RESET;
                    setFlags[IRQ_HI]  = 1'b1;
                    nxt_state.hiMatch = 1'b1;
                    nxt_state.adcTrig = ADC_TRIG_EN;
                end else begin
                    nxt_state.hiCount = state_ff.hiCount + ONE_WORD;
                end
            end
        end

        // register writes; a count write beats a same-cycle tick
        if (bus.wrStb) begin
            unique case (bus.addr)
                REG_LO_CTRL: begin
                    // unimplemented bits stay zero
                    nxt_state.loCtrl = ptmr_ctrl_t'(bus.wrData & LO_CTRL_WMASK);
                end
                REG_HI_CTRL: begin
                    // no pair bit here; bits 3-2 stay zero
                    nxt_state.hiCtrl = ptmr_ctrl_t'(bus.wrData & HI_CTRL_WMASK);
                end
                REG_LO_PERIOD: begin
                    nxt_state.loPeriod = bus.wrData;
                end
                REG_HI_PERIOD: begin
                    nxt_state.hiPeriod = bus.wrData;
                end
                REG_LO_COUNT: begin
                    nxt_state.loCount = bus.wrData;
                end
                REG_HI_COUNT: begin
                    nxt_state.hiCount = bus.wrData;
                end
                REG_IRQ_MASK: begin
                    nxt_state.mask = bus.wrData[IRQ_W-1:0];
                end
                default: begin
                    // status handled apart; others ignored
                end
            endcase
        end

        // sticky flags: a set in the clearing cycle survives
        nxt_state.status = (state_ff.status & ~clrFlags) | setFlags;

        // reads answer in the next cycle; unmapped reads give zero
        if (bus.rdStb) begin
            unique case (bus.addr)
                REG_LO_CTRL: begin
                    nxt_state.rdData = state_ff.loCtrl;
                end
                REG_HI_CTRL: begin
                    nxt_state.rdData = state_ff.hiCtrl;
                end
                REG_LO_PERIOD: begin
                    nxt_state.rdData = state_ff.loPeriod;
                end
                REG_HI_PERIOD: begin
                    nxt_state.rdData = state_ff.hiPeriod;
                end
                REG_LO_COUNT: begin
                    nxt_state.rdData = state_ff.loCount;
                    // snapshot upper word so a later hold read matches
                    if (pairMode) begin
                        nxt_state.hold = state_ff.hiCount;
                    end
                end
                REG_HI_COUNT: begin
                    nxt_state.rdData = state_ff.hiCount;
                end
                REG_HOLD: begin
                    nxt_state.rdData = state_ff.hold;
                end
                REG_IRQ_STAT: begin
                    nxt_state.rdData = {{(DATA_W-IRQ_W){1'b0}}, state_ff.status};
                end
                REG_IRQ_MASK: begin
                    nxt_state.rdData = {{(DATA_W-IRQ_W){1'b0}}, state_ff.mask};
                end
                default: begin
                    nxt_state.rdData = ZERO_WORD;
                end
            endcase
        end
    end

    // state register; everything starts stopped, 16-bit, internal clock
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff.loCtrl   <= ptmr_ctrl_t'(CTRL_RESET);
            state_ff.hiCtrl   <= ptmr_ctrl_t'(CTRL_RESET);
            state_ff.loPeriod <= PERIOD_RESET;
            state_ff.hiPeriod <= PERIOD_RESET;
            state_ff.loCount  <= COUNT_RESET;
            state_ff.hiCount  <= COUNT_RESET;
            state_ff.hold     <= COUNT_RESET;
            state_ff.status   <= IRQ_RESET;
            state_ff.mask     <= IRQ_RESET;
            state_ff.rdData   <= ZERO_WORD;
            state_ff.loMatch  <= 1'b0;
            state_ff.hiMatch  <= 1'b0;
            state_ff.adcTrig  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // outputs; irq is a level while any unmasked flag is set
    assign rdData            = state_ff.rdData;
    assign irq               = |(state_ff.status & state_ff.mask);
    assign lowMatch          = state_ff.loMatch;
    assign pairInterruptFlag = state_ff.status[IRQ_HI];
    assign adcTrigger        = state_ff.adcTrig;
endmodule
`default_nettype wire
